// [hdl/mhf_filter.sv]
// command engine, configuration tail and multicast hash filter of an ethernet mac
//
// Behaviour
// - with multiple individual-address set, the hash also qualifies individual frames.
// - priority-location bit picks byte 19 (0) or byte 31 (1); default 1.
// - accept-all-multicast accepts every multicast frame without the hash; default off.
// - engine keeps the first eight configure bytes; the rest go to execution.
// - configure runs fetch, byte transfer, wait for update, then status complete+ok.
// - selective reset keeps configuration; software or hardware reset restores defaults.
// - command field bits 18:16 equal to 011b means multicast setup.
// - end-of-list block sends the engine idle and always raises the idle event.
// - suspend block without end-of-list sends the engine suspended; inactive event only when enabled.
// - interrupt-request bit raises the command-done event; otherwise none.
// - driver clears complete bit 15; device sets it when the command ends.
// - device sets ok bit 13 on success; complete without ok means failure.
// - next block address is base plus the 32-bit link field.
// - 14-bit count is list length; remainder below six bytes is dropped.
// - a zero count clears the hash table.
// - multicast setup latches count, transfers the list, waits, then completes.
// - 64-bit hash table is cleared then loaded in six-byte groups.
// - each full group sets the bit indexed by crc bits 7:2.
// - accept when the multicast bit is one and the hashed bit is set.
// - software reset clears the whole hash table.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

module mhf_filter (
  input wire logic clk_sys,
  input wire logic reset,
  input wire mhf_pkg::mhf_apb_req_s apb_req,
  output mhf_pkg::mhf_apb_rsp_s apb_rsp,
  output mhf_pkg::mhf_mem_req_s mem_req,
  input wire mhf_pkg::mhf_mem_rsp_s mem_rsp,
  input wire mhf_pkg::mhf_rx_s rx,
  output logic rx_done,
  output logic rx_accept,
  output logic [4:0] prio_byte_index,
  output logic engine_idle_event,
  output logic engine_inactive_event,
  output logic command_done_event
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  mhf_pkg::mhf_state_s s_q;
  mhf_pkg::mhf_state_s s_d;
  logic wr;
  logic swrst;
  logic selrst;
  logic [7:0] byte_v;
  logic [31:0] crc_v;
  logic [31:0] rcrc_v;
  logic [31:0] nxt_v;
  logic mc_v;
  logic hit_v;

  // one byte of the reflected ethernet crc, lsb of each byte first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ mhf_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign swrst = wr && apb_req.paddr == mhf_pkg::REG_CTRL && apb_req.pwdata[mhf_pkg::CTRL_SWRST];
  assign selrst = wr && apb_req.paddr == mhf_pkg::REG_CTRL && apb_req.pwdata[mhf_pkg::CTRL_SELRST];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    byte_v = s_q.word[{s_q.bsel, 3'b000} +: 8];
    crc_v = crc_byte((s_q.grp == 3'h0) ? mhf_pkg::CRC_PRESET : s_q.hcrc, byte_v);
    rcrc_v = crc_byte((s_q.rcnt == 3'h0) ? mhf_pkg::CRC_PRESET : s_q.rcrc, rx.data);
    nxt_v = s_q.base + s_q.link;
    mc_v = (s_q.rcnt == 3'h0) ? rx.data[0] : s_q.rmc;
    hit_v = s_q.hash[rcrc_v[7:2]];
    s_d.ev_idle = 1'b0;
    s_d.ev_inact = 1'b0;
    s_d.ev_done = 1'b0;
    s_d.rx_done = 1'b0;

    // software register writes
    if (wr) begin
      case (apb_req.paddr)
        mhf_pkg::REG_CTRL: s_d.cna_en = apb_req.pwdata[mhf_pkg::CTRL_CNAEN];
        mhf_pkg::REG_BASE: s_d.base = apb_req.pwdata;
        mhf_pkg::REG_PTR: s_d.ptr = apb_req.pwdata;
        default: ;
      endcase
    end

    // command engine; memory requests hold until the one-cycle ack
    case (s_q.eng)
      mhf_pkg::E_IDLE: begin
        if (wr && apb_req.paddr == mhf_pkg::REG_CTRL && apb_req.pwdata[mhf_pkg::CTRL_START]) begin
          s_d.blk = s_q.base + s_q.ptr;
          s_d.m = '{req: 1'b1, we: 1'b0, addr: s_q.base + s_q.ptr, wdata: 32'h0000_0000};
          s_d.eng = mhf_pkg::E_HDR;
        end
      end
      mhf_pkg::E_SUSP: begin
        if (wr && apb_req.paddr == mhf_pkg::REG_CTRL && apb_req.pwdata[mhf_pkg::CTRL_RESUME]) begin
          s_d.m = '{req: 1'b1, we: 1'b0, addr: s_q.blk, wdata: 32'h0000_0000};
          s_d.eng = mhf_pkg::E_HDR;
        end
      end
      mhf_pkg::E_HDR: begin
        if (mem_rsp.ack) begin
          s_d.cmd_hi = mem_rsp.rdata[31:16];
          s_d.m.addr = s_q.blk + mhf_pkg::OFS_LINK;
          s_d.eng = mhf_pkg::E_LINK;
        end
      end
      mhf_pkg::E_LINK: begin
        if (mem_rsp.ack) begin
          s_d.link = mem_rsp.rdata;
          s_d.ok = 1'b1;
          s_d.m.addr = s_q.blk + mhf_pkg::OFS_CNT;
          s_d.eng = mhf_pkg::E_CNT;
        end
      end
      mhf_pkg::E_CNT: begin
        if (mem_rsp.ack) begin
          s_d.idx = 14'h0000;
          s_d.bsel = 2'h0;
          s_d.grp = 3'h0;
          s_d.m.req = 1'b0;
          if (s_q.cmd_hi[2:0] == mhf_pkg::CMD_MCSETUP) begin
            // latch the count and restart the table before any group lands
            s_d.cnt = mem_rsp.rdata[mhf_pkg::MC_CNT_W-1:0];
            s_d.hash = 64'h0000_0000_0000_0000;
            // first two list bytes share this word with the count, so no refetch
            s_d.word = mem_rsp.rdata;
            s_d.bsel = mhf_pkg::OFS_LIST[1:0];
            s_d.waddr = s_q.blk + mhf_pkg::OFS_CNT;
            if (mem_rsp.rdata[mhf_pkg::MC_CNT_W-1:0] == 14'h0000) begin
              s_d.eng = mhf_pkg::E_SYNC;
            end else begin
              s_d.eng = mhf_pkg::E_BYTES;
            end
          end else if (s_q.cmd_hi[2:0] == mhf_pkg::CMD_CONFIG) begin
            // configure bytes start in this very word, byte 0 holds the count
            s_d.cnt = {8'h00, mem_rsp.rdata[mhf_pkg::CFG_CNT_W-1:0]};
            s_d.word = mem_rsp.rdata;
            s_d.waddr = s_q.blk + mhf_pkg::OFS_CNT;
            s_d.eng = (mem_rsp.rdata[mhf_pkg::CFG_CNT_W-1:0] == 6'h00) ?
                      mhf_pkg::E_SYNC : mhf_pkg::E_BYTES;
          end else begin
            s_d.ok = 1'b0;
            s_d.eng = mhf_pkg::E_SYNC;
          end
        end
      end
      mhf_pkg::E_DATA: begin
        if (mem_rsp.ack) begin
          s_d.m.req = 1'b0;
          s_d.word = mem_rsp.rdata;
          s_d.bsel = 2'h0;
          s_d.eng = mhf_pkg::E_BYTES;
        end
      end
      mhf_pkg::E_BYTES: begin
        // one byte per cycle from the fetched word
        if (s_q.cmd_hi[2:0] == mhf_pkg::CMD_MCSETUP) begin
          if (s_q.grp == mhf_pkg::GROUP_LAST) begin
            s_d.hash[crc_v[7:2]] = 1'b1;
            s_d.grp = 3'h0;
          end else begin
            s_d.hcrc = crc_v;
            s_d.grp = s_q.grp + 3'h1;
          end
        end else if (s_q.idx < mhf_pkg::CFG_HEAD_BYTES) begin
          s_d.cfg_head[{s_q.idx[2:0], 3'b000} +: 8] = byte_v;
        end else if (s_q.idx == mhf_pkg::CFG_BYTE_MIA) begin
          s_d.multi_ia = byte_v[mhf_pkg::CFG_BIT_MIA];
          s_d.prio_idx = byte_v[mhf_pkg::CFG_BIT_PLOC] ?
                         mhf_pkg::PRIO_LATE : mhf_pkg::PRIO_EARLY;
        end else if (s_q.idx == mhf_pkg::CFG_BYTE_MCALL) begin
          s_d.mc_all = byte_v[mhf_pkg::CFG_BIT_MCALL];
        end
        s_d.idx = s_q.idx + 14'h0001;
        s_d.bsel = s_q.bsel + 2'h1;
        // a trailing partial group simply never reaches the table
        if (s_q.idx + 14'h0001 == s_q.cnt) begin
          s_d.eng = mhf_pkg::E_SYNC;
        end else if (s_q.bsel == 2'h3) begin
          s_d.waddr = s_q.waddr + mhf_pkg::OFS_WORD;
          s_d.m = '{req: 1'b1, we: 1'b0, addr: s_q.waddr + mhf_pkg::OFS_WORD,
                    wdata: 32'h0000_0000};
          s_d.eng = mhf_pkg::E_DATA;
        end
      end
      mhf_pkg::E_SYNC: begin
        // execution machine has settled; post the status word
        s_d.m = '{req: 1'b1, we: 1'b1, addr: s_q.blk,
                  wdata: {s_q.cmd_hi, mhf_pkg::STAT_DONE |
                          (s_q.ok ? mhf_pkg::STAT_OK : 16'h0000)}};
        s_d.eng = mhf_pkg::E_STAT;
      end
      mhf_pkg::E_STAT: begin
        if (mem_rsp.ack) begin
          s_d.m.req = 1'b0;
          s_d.ev_done = s_q.cmd_hi[mhf_pkg::CMD_IRQ];
          s_d.blk = nxt_v;
          if (s_q.cmd_hi[mhf_pkg::CMD_EL]) begin
            s_d.eng = mhf_pkg::E_IDLE;
            s_d.ev_idle = 1'b1;
          end else if (s_q.cmd_hi[mhf_pkg::CMD_SUSP]) begin
            s_d.eng = mhf_pkg::E_SUSP;
            s_d.ev_inact = s_q.cna_en;
          end else begin
            s_d.m = '{req: 1'b1, we: 1'b0, addr: nxt_v, wdata: 32'h0000_0000};
            s_d.eng = mhf_pkg::E_HDR;
          end
        end
      end
      default: s_d.eng = mhf_pkg::E_IDLE;
    endcase

    // receive side: hash the six destination bytes as they arrive
    if (rx.start) begin
      s_d.rcnt = 3'h0;
    end else if (rx.valid && s_q.rcnt <= mhf_pkg::GROUP_LAST) begin
      s_d.rcrc = rcrc_v;
      s_d.rmc = mc_v;
      s_d.rcnt = s_q.rcnt + 3'h1;
      if (s_q.rcnt == mhf_pkg::GROUP_LAST) begin
        s_d.rx_done = 1'b1;
        s_d.rx_accept = mc_v ? (s_q.mc_all | hit_v) : (s_q.multi_ia & hit_v);
      end
    end

    // port resets: selective keeps configuration, software restores it all
    if (selrst) begin
      s_d.eng = mhf_pkg::E_IDLE;
      s_d.m = '0;
    end
    if (swrst) begin
      s_d = mhf_pkg::STATE_RST;
    end
  end

  // single register for the whole state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= mhf_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped addresses flag pslverr
  // ----------------------------------------------------------------
  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = 1'b0;
    apb_rsp.prdata = 32'h0000_0000;
    if (apb_req.psel && apb_req.penable) begin
      case (apb_req.paddr)
        mhf_pkg::REG_CTRL: apb_rsp.prdata = {27'h0000000, s_q.cna_en, 4'h0};
        mhf_pkg::REG_BASE: apb_rsp.prdata = s_q.base;
        mhf_pkg::REG_PTR: apb_rsp.prdata = s_q.ptr;
        mhf_pkg::REG_STAT: apb_rsp.prdata = {19'h00000, s_q.prio_idx, s_q.mc_all,
                                             s_q.multi_ia, s_q.cna_en, 1'b0, s_q.eng};
        mhf_pkg::REG_HASH_LO: apb_rsp.prdata = s_q.hash[31:0];
        mhf_pkg::REG_HASH_HI: apb_rsp.prdata = s_q.hash[63:32];
        default: apb_rsp.pslverr = 1'b1;
      endcase
    end
  end

  assign mem_req = s_q.m;
  assign rx_done = s_q.rx_done;
  assign rx_accept = s_q.rx_accept;
  assign prio_byte_index = s_q.prio_idx;
  assign engine_idle_event = s_q.ev_idle;
  assign engine_inactive_event = s_q.ev_inact;
  assign command_done_event = s_q.ev_done;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_status_complete: assert property (
    (s_q.m.req && s_q.m.we) |-> (s_q.m.wdata[15] && s_q.m.addr == s_q.blk))
    else $error("status write without complete bit");
  chk_status_ok: assert property (
    (s_q.eng == mhf_pkg::E_SYNC && s_q.cmd_hi[2:0] == mhf_pkg::CMD_MCSETUP
      && !swrst && !selrst) |=> s_q.m.wdata[13])
    else $error("multicast setup finished without ok");
  chk_idle_event: assert property (
    $rose(s_q.ev_idle) |-> (s_q.eng == mhf_pkg::E_IDLE && $past(s_q.eng) == mhf_pkg::E_STAT))
    else $error("idle event outside end of list");
  chk_inactive_event: assert property (
    s_q.ev_inact |-> ($past(s_q.eng) == mhf_pkg::E_STAT && $past(s_q.cna_en)
      && $past(s_q.cmd_hi[mhf_pkg::CMD_SUSP])))
    else $error("inactive event without suspend");
  chk_suspend_state: assert property (
    (s_q.eng == mhf_pkg::E_STAT && mem_rsp.ack && !s_q.cmd_hi[mhf_pkg::CMD_EL]
      && s_q.cmd_hi[mhf_pkg::CMD_SUSP] && !swrst && !selrst) |=> s_q.eng == mhf_pkg::E_SUSP)
    else $error("suspend block did not suspend the engine");
  chk_done_event: assert property (
    (s_q.eng == mhf_pkg::E_STAT && mem_rsp.ack && !swrst && !selrst)
      |=> (s_q.ev_done == $past(s_q.cmd_hi[mhf_pkg::CMD_IRQ])))
    else $error("done event does not follow request bit");
  chk_link_add: assert property (
    (s_q.eng == mhf_pkg::E_STAT && mem_rsp.ack && !s_q.cmd_hi[mhf_pkg::CMD_EL]
      && !s_q.cmd_hi[mhf_pkg::CMD_SUSP] && !swrst && !selrst)
      |=> (s_q.m.req && s_q.m.addr == $past(s_q.base) + $past(s_q.link)))
    else $error("next block address is not base plus link");
  chk_hash_swrst: assert property (
    swrst |=> (s_q.hash == 64'h0000_0000_0000_0000 && s_q.prio_idx == mhf_pkg::PRIO_LATE))
    else $error("software reset left hash or defaults");
  chk_prio_range: assert property (
    s_q.prio_idx == mhf_pkg::PRIO_LATE || s_q.prio_idx == mhf_pkg::PRIO_EARLY)
    else $error("priority location outside its two values");
  // receive checks look one cycle back: a configure may land in the deciding cycle
  chk_mc_all: assert property (
    (s_q.rx_done && s_q.rmc && $past(s_q.mc_all)) |-> s_q.rx_accept)
    else $error("multicast frame refused with accept all");
  chk_unicast_drop: assert property (
    (s_q.rx_done && !s_q.rmc && !$past(s_q.multi_ia)) |-> !s_q.rx_accept)
    else $error("individual frame accepted by hash");
  chk_table_clear: assert property (
    (s_q.eng == mhf_pkg::E_CNT && mem_rsp.ack && s_q.cmd_hi[2:0] == mhf_pkg::CMD_MCSETUP
      && !swrst && !selrst) |=> (s_q.hash == 64'h0000_0000_0000_0000))
    else $error("hash table not cleared at setup");
  chk_zero_count: assert property (
    (s_q.eng == mhf_pkg::E_CNT && mem_rsp.ack && s_q.cmd_hi[2:0] == mhf_pkg::CMD_MCSETUP
      && mem_rsp.rdata[mhf_pkg::MC_CNT_W-1:0] == 14'h0000 && !swrst && !selrst)
      |=> (s_q.eng == mhf_pkg::E_SYNC && s_q.hash == 64'h0000_0000_0000_0000))
    else $error("zero count did not skip to status with a clear table");

endmodule

// [common/mhf_pkg.sv]
// package of constants and carrier types for the multicast hash filter block
package mhf_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_PTR = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_HASH_LO = 8'h10;
  localparam logic [7:0] REG_HASH_HI = 8'h14;
  // control register bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_RESUME = 1;
  localparam int CTRL_SWRST = 2;
  localparam int CTRL_SELRST = 3;
  localparam int CTRL_CNAEN = 4;

  // ----------------------------------------------------------------
  // command block layout
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_LINK = 32'h0000_0004;
  localparam logic [31:0] OFS_CNT = 32'h0000_0008;
  localparam logic [31:0] OFS_LIST = 32'h0000_000A; // list opens in the upper half of word 2
  localparam logic [31:0] OFS_WORD = 32'h0000_0004;
  // positions inside the upper half (command word) of word 0
  localparam int CMD_EL = 15;
  localparam int CMD_SUSP = 14;
  localparam int CMD_IRQ = 13;
  localparam logic [2:0] CMD_CONFIG = 3'h2;
  localparam logic [2:0] CMD_MCSETUP = 3'h3;
  // status half of word 0
  localparam logic [15:0] STAT_DONE = 16'h8000;
  localparam logic [15:0] STAT_OK = 16'h2000;
  localparam int MC_CNT_W = 14;
  localparam int CFG_CNT_W = 6;

  // ----------------------------------------------------------------
  // configuration bytes held by the execution machine
  // ----------------------------------------------------------------
  localparam logic [13:0] CFG_HEAD_BYTES = 14'h0008;
  localparam logic [13:0] CFG_BYTE_MIA = 14'h0014;
  localparam logic [13:0] CFG_BYTE_MCALL = 14'h0015;
  localparam int CFG_BIT_MIA = 6;
  localparam int CFG_BIT_PLOC = 5;
  localparam int CFG_BIT_MCALL = 3;
  localparam logic [4:0] PRIO_EARLY = 5'h13;
  localparam logic [4:0] PRIO_LATE = 5'h1F;

  // ----------------------------------------------------------------
  // hashing
  // ----------------------------------------------------------------
  localparam logic [2:0] GROUP_LAST = 3'h5;
  localparam logic [31:0] CRC_PRESET = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    E_IDLE, E_SUSP, E_HDR, E_LINK, E_CNT, E_DATA, E_BYTES, E_SYNC, E_STAT
  } mhf_eng_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mhf_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mhf_apb_rsp_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mhf_mem_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } mhf_mem_rsp_s;

  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
  } mhf_rx_s;

  typedef struct packed {
    mhf_eng_e eng;
    logic [31:0] base;
    logic [31:0] ptr;
    logic [31:0] blk;
    logic [15:0] cmd_hi;
    logic [31:0] link;
    logic [13:0] cnt;
    logic [13:0] idx;
    logic [31:0] word;
    logic [1:0] bsel;
    logic [31:0] waddr;
    logic ok;
    logic [63:0] cfg_head;
    logic multi_ia;
    logic [4:0] prio_idx;
    logic mc_all;
    logic cna_en;
    logic [63:0] hash;
    logic [31:0] hcrc;
    logic [2:0] grp;
    logic [31:0] rcrc;
    logic [2:0] rcnt;
    logic rmc;
    logic rx_done;
    logic rx_accept;
    mhf_mem_req_s m;
    logic ev_idle;
    logic ev_inact;
    logic ev_done;
  } mhf_state_s;

  localparam mhf_state_s STATE_RST = '{eng: E_IDLE, prio_idx: PRIO_LATE, default: '0};

endpackage

// [test/mhf_mem_model.sv]
// memory partner that answers the command engine's word requests
`timescale 1ns/1ps

module mhf_mem_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire mhf_pkg::mhf_mem_req_s mem_req,
  output mhf_pkg::mhf_mem_rsp_s mem_rsp
);
  logic [31:0] mem [0:255];
  int dly;

  // ----------------------------------------------------------------
  // start state: empty memory, no answer pending
  // ----------------------------------------------------------------
  initial begin
    mem_rsp = '0;
    dly = 0;
    foreach (mem[k]) mem[k] = '0;
  end

  // one ack per request after a random wait of zero to two cycles;
  // rdata is inverted off an ack so a stale word never passes as data
  always @(posedge clk_sys) begin
    mem_rsp.ack <= 1'b0;
    mem_rsp.rdata <= ~mem_rsp.rdata;
    if (!reset && mem_req.req && !mem_rsp.ack) begin
      if (dly == 0) begin
        mem_rsp.ack <= 1'b1;
        dly <= $urandom % 3;
        if (mem_req.we) mem[mem_req.addr[9:2]] <= mem_req.wdata;
        else mem_rsp.rdata <= mem[mem_req.addr[9:2]];
      end else begin
        dly <= dly - 1;
      end
    end
  end
endmodule

// [test/mhf_filter_tb_top.sv]
// self-checking bench for the multicast hash filter block
`timescale 1ns/1ps

module mhf_filter_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  mhf_pkg::mhf_apb_req_s apb_req = '0;
  mhf_pkg::mhf_apb_rsp_s apb_rsp;
  mhf_pkg::mhf_mem_req_s mem_req;
  mhf_pkg::mhf_mem_rsp_s mem_rsp;
  mhf_pkg::mhf_rx_s rx = '0;
  logic rx_done;
  logic rx_accept;
  logic [4:0] prio_byte_index;
  logic engine_idle_event;
  logic engine_inactive_event;
  logic command_done_event;
  int err_count = 0;
  int n_compared = 0;
  int n_idle, n_inact, n_done;
  logic [31:0] rd;
  logic perr;
  logic [63:0] exp_h;
  bit mia, mcall;
  bit [47:0] aq[$];

  always #50 clk_sys = ~clk_sys;

  mhf_filter dut_u (
    .clk_sys(clk_sys), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .rx(rx), .rx_done(rx_done),
    .rx_accept(rx_accept), .prio_byte_index(prio_byte_index),
    .engine_idle_event(engine_idle_event), .engine_inactive_event(engine_inactive_event),
    .command_done_event(command_done_event)
  );

  mhf_mem_model mem_u (.clk_sys(clk_sys), .reset(reset), .mem_req(mem_req), .mem_rsp(mem_rsp));

  // event pulses are counted so each run can be checked for its exact mix
  always @(posedge clk_sys) begin
    if (!reset) begin
      n_idle += int'(engine_idle_event === 1'b1);
      n_inact += int'(engine_inactive_event === 1'b1);
      n_done += int'(command_done_event === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // apb transfer held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    perr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  // reflected crc from the all-ones preset, index from bits 7:2
  function automatic int hidx(input bit [47:0] a);
    bit [31:0] c;
    c = mhf_pkg::CRC_PRESET;
    for (int i = 0; i < 48; i++) c = (c[0] ^ a[i]) ? (c >> 1) ^ mhf_pkg::CRC_POLY : c >> 1;
    return int'(c[7:2]);
  endfunction

  task automatic poke(input int a, input logic [7:0] b);
    mem_u.mem[a[9:2]][8*a[1:0] +: 8] = b;
  endtask

  // reserved bits stay zero and the complete bit is cleared by the host
  task automatic blk(input int at, input logic [2:0] fl, input logic [2:0] f, input int link,
                     input int cnt);
    mem_u.mem[at/4] = {fl, 10'h000, f, 16'h0000};
    mem_u.mem[at/4+1] = link;
    mem_u.mem[at/4+2] = cnt;
  endtask

  // list of n random multicast addresses; only whole counted groups hash
  task automatic mclist(input int at, input int n, input int cnt);
    bit [47:0] a;
    exp_h = '0;
    aq.delete();
    for (int g = 0; g < n; g++) begin
      a = 48'({$urandom(), $urandom()});
      a[0] = 1'b1;
      for (int k = 0; k < 6; k++) poke(at + 10 + 6*g + k, a[8*k +: 8]);
      if (g < cnt / 6) begin
        exp_h[hidx(a)] = 1'b1;
        aq.push_back(a);
      end
    end
  endtask

  task automatic run(input logic [31:0] c);
    n_idle = 0;
    n_inact = 0;
    n_done = 0;
    apb(1'b1, mhf_pkg::REG_CTRL, c);
    for (int k = 0; k < 200; k++) begin
      apb(1'b0, mhf_pkg::REG_STAT, 32'h0000_0000);
      if (rd[3:0] <= 4'h1) break;
    end
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic hash_chk();
    logic [31:0] hi;
    apb(1'b0, mhf_pkg::REG_HASH_HI, 32'h0000_0000);
    hi = rd;
    apb(1'b0, mhf_pkg::REG_HASH_LO, 32'h0000_0000);
    chk({hi, rd}, exp_h);
  endtask

  task automatic frame(input bit [47:0] a);
    bit hit;
    @(posedge clk_sys);
    rx <= '{start: 1'b1, valid: 1'b0, data: 8'h00};
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      rx <= '{start: 1'b0, valid: 1'b1, data: a[8*k +: 8]};
    end
    @(posedge clk_sys);
    rx <= '0;
    for (int k = 0; k < 4 && rx_done !== 1'b1; k++) @(posedge clk_sys);
    hit = exp_h[hidx(a)];
    chk(rx_done, 1'b1);
    chk(rx_accept, a[0] ? (mcall | hit) : (mia & hit));
  endtask

  // loaded addresses, their individual twins, then random frames
  task automatic frames();
    foreach (aq[k]) begin
      frame(aq[k]);
      frame(aq[k] ^ 48'h0000_0000_0001);
    end
    repeat (6) frame(48'({$urandom(), $urandom()}));
  endtask

  task automatic test_done();
    $display("TB: %0d compared, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under 20000 cycles
  // ----------------------------------------------------------------
  initial begin
    #(20000 * 100);
    err_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(71478));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, mhf_pkg::REG_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_1F00);
    chk(prio_byte_index, 5'h1F);
    exp_h = '0;
    hash_chk();
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({perr, rd}, 33'h1_0000_0000);
    $display("TB: test reset done");
    // multicast setup, 14 bytes: two groups hash, two trailing bytes do not
    blk(32'h100, 3'b011, mhf_pkg::CMD_MCSETUP, 32'h1C0, 14);
    mclist(32'h100, 3, 14);
    apb(1'b1, mhf_pkg::REG_BASE, 32'h0000_0040);
    apb(1'b1, mhf_pkg::REG_PTR, 32'h0000_00C0);
    run(32'h0000_0001);
    chk(rd[3:0], 4'h1);
    chk(mem_u.mem[32'h40], {3'b011, 10'h000, 3'h3, 16'hA000});
    chk({n_idle[7:0], n_inact[7:0], n_done[7:0]}, 24'h00_00_01);
    hash_chk();
    frames();
    $display("TB: test multicast setup done");
    // resume fetches base plus link: configure with last block flag
    blk(32'h200, 3'b100, mhf_pkg::CMD_CONFIG, 32'h0, 22);
    poke(32'h200 + 28, 8'h40);
    poke(32'h200 + 29, 8'h08);
    mia = 1'b1;
    mcall = 1'b1;
    run(32'h0000_0002);
    chk(mem_u.mem[32'h80], {3'b100, 10'h000, 3'h2, 16'hA000});
    chk({n_idle[7:0], n_inact[7:0], n_done[7:0]}, 24'h01_00_00);
    chk(prio_byte_index, 5'h13);
    apb(1'b0, mhf_pkg::REG_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_13C0);
    hash_chk();
    frames();
    $display("TB: test configure done");
    // selective reset keeps configuration and table, software reset clears both
    apb(1'b1, mhf_pkg::REG_CTRL, 32'h0000_0008);
    apb(1'b0, mhf_pkg::REG_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_13C0);
    hash_chk();
    apb(1'b1, mhf_pkg::REG_CTRL, 32'h0000_0004);
    apb(1'b0, mhf_pkg::REG_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_1F00);
    chk(prio_byte_index, 5'h1F);
    exp_h = '0;
    aq.delete();
    hash_chk();
    mia = 1'b0;
    mcall = 1'b0;
    $display("TB: test resets done");
    // one group loaded, a zero count wipes it, an unknown command fails and suspends
    blk(32'h300, 3'b000, mhf_pkg::CMD_MCSETUP, 32'h340, 6);
    mclist(32'h300, 1, 6);
    blk(32'h380, 3'b000, mhf_pkg::CMD_MCSETUP, 32'h360, 0);
    blk(32'h3A0, 3'b010, 3'h7, 32'h0, 0);
    apb(1'b1, mhf_pkg::REG_BASE, 32'h0000_0040);
    apb(1'b1, mhf_pkg::REG_PTR, 32'h0000_02C0);
    run(32'h0000_0011);
    chk(mem_u.mem[32'hC0], {3'b000, 10'h000, 3'h3, 16'hA000});
    chk(mem_u.mem[32'hE0], {3'b000, 10'h000, 3'h3, 16'hA000});
    chk(mem_u.mem[32'hE8], {3'b010, 10'h000, 3'h7, 16'h8000});
    chk({n_idle[7:0], n_inact[7:0], n_done[7:0]}, 24'h00_01_00);
    exp_h = '0;
    aq.delete();
    hash_chk();
    frames();
    $display("TB: test zero count done");
    test_done();
  end
endmodule
